// File: rtl/agu_top.v
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "agu_consts.vh"

module agu_top #(
  parameter NREG = 16
) (
  input wire SYS_CLK_I,
  input wire RST_N_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [8:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  input wire X_REQ_I,
  input wire [2:0] X_MODE_I,
  input wire [3:0] X_PTR_I,
  input wire [3:0] X_BASE_I,
  input wire [15:0] X_MOD_I,
  input wire [15:0] X_LIT_I,
  input wire [15:0] X_FILE_I,
  input wire X_XFER_I,
  output reg [15:0] X_EA_O,
  output reg X_EA_VALID_O,
  output reg X_EA_IS_DATA_O,
  output reg [15:0] X_DATA_O,
  output reg [15:0] X_OP1_O,
  output reg X_DEST_W0_O,
  input wire Y_REQ_I,
  input wire [2:0] Y_MODE_I,
  input wire [3:0] Y_PTR_I,
  input wire [3:0] Y_BASE_I,
  input wire [15:0] Y_MOD_I,
  output reg [15:0] Y_EA_O,
  output reg Y_EA_VALID_O,
  input wire WR_EN_I,
  input wire [3:0] WR_IDX_I,
  input wire [15:0] WR_DATA_I,
  output reg INT_DISABLE_O
);

  ////////////////////////////////////////////////////////////////
  // Helpers

  // Mirror of a halfword, used by the reverse-carry add
  function [15:0] rev16;
    input [15:0] v;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        rev16[k] = v[15-k];
      end
    end
  endfunction

  // Jumps past a bound still wrap because the test is greater or less, not equal
  function [15:0] circ_fix;
    input [15:0] a;
    input [15:0] s;
    input [15:0] e;
    reg [15:0] len;
    begin
      len = e - s + 16'h0001;
      if (a > e) begin
        circ_fix = a - len;
      end else if (a < s) begin
        circ_fix = a + len;
      end else begin
        circ_fix = a;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Registers

  reg [15:0] ctrl_r;
  reg [15:0] x_start_r;
  reg [15:0] x_end_r;
  reg [15:0] y_start_r;
  reg [15:0] y_end_r;
  reg [15:0] bitrev_r;
  reg [`AGU_INTERRUPT_DISABLE_COUNT_W-1:0] interrupt_disable_count_r;
  reg [15:0] default_working_reg_r [0:NREG-1];

  wire [3:0] x_circ_pointer_select = ctrl_r[`AGU_XSEL_LSB+3:`AGU_XSEL_LSB];
  wire [3:0] y_circ_pointer_select = ctrl_r[`AGU_YSEL_LSB+3:`AGU_YSEL_LSB];
  wire [3:0] bitrev_pointer_select = ctrl_r[`AGU_BSEL_LSB+3:`AGU_BSEL_LSB];
  wire x_circ_enable = ctrl_r[`AGU_XCIRC_EN_BIT];
  wire y_circ_enable = ctrl_r[`AGU_YCIRC_EN_BIT];
  wire bitrev_enable = bitrev_r[`AGU_BITREV_EN_BIT];
  wire [15:0] bitrev_pivot = {1'b0, bitrev_r[14:0]};

  ////////////////////////////////////////////////////////////////
  // X generator

  wire [15:0] x_ptr = default_working_reg_r[X_PTR_I];
  wire [15:0] x_base = default_working_reg_r[X_BASE_I];
  wire x_circ_on = x_circ_enable && (x_circ_pointer_select != `AGU_SEL_OFF) &&
    (x_circ_pointer_select == X_PTR_I);
  wire x_is_mod = (X_MODE_I == `AGU_M_POST) || (X_MODE_I == `AGU_M_PRE);
  // Only an increment counts; a decrementing pointer takes the plain linear or circular step
  wire x_brev_on = bitrev_enable && (bitrev_pointer_select != `AGU_SEL_OFF) &&
    (bitrev_pointer_select == X_PTR_I) && x_is_mod && !X_MOD_I[15];
  // Reversing both addends makes the carry ripple from the top bit down
  wire [15:0] x_ptr_rev = rev16(x_ptr);
  wire [15:0] x_pivot_rev = rev16({bitrev_pivot[14:0], 1'b0});
  wire [15:0] x_brev_sum = x_ptr_rev + x_pivot_rev;
  wire [15:0] x_step = x_brev_on ? rev16(x_brev_sum) : (x_ptr + X_MOD_I);
  wire [15:0] x_step_fix = (x_circ_on && !x_brev_on) ?
    circ_fix(x_step, x_start_r, x_end_r) : x_step;
  // Offset modes correct the address only; the pointer is left alone
  wire [15:0] x_reg_sum = x_ptr + x_base;
  wire [15:0] x_lit_sum = x_ptr + X_LIT_I;

  reg [15:0] x_ea_nxt;
  reg [15:0] x_data_nxt;
  reg x_wb_nxt;
  reg x_is_data_nxt;

  always @* begin
    x_ea_nxt = x_ptr;
    x_data_nxt = 16'h0000;
    x_wb_nxt = 1'b0;
    x_is_data_nxt = 1'b0;
    case (X_MODE_I)
      `AGU_M_FILE: begin
        x_ea_nxt = X_XFER_I ? X_FILE_I : (X_FILE_I & `AGU_NEAR_MASK);
      end
      `AGU_M_DIRECT: begin
        x_ea_nxt = 16'h0000;
        x_data_nxt = x_ptr;
        x_is_data_nxt = 1'b1;
      end
      `AGU_M_LIT5: begin
        x_ea_nxt = 16'h0000;
        x_data_nxt = {11'h000, X_LIT_I[4:0]};
        x_is_data_nxt = 1'b1;
      end
      `AGU_M_IND: begin
        x_ea_nxt = x_ptr;
      end
      `AGU_M_POST: begin
        x_ea_nxt = x_ptr;
        x_wb_nxt = 1'b1;
      end
      `AGU_M_PRE: begin
        x_ea_nxt = x_step_fix;
        x_wb_nxt = 1'b1;
      end
      `AGU_M_REGOFS: begin
        x_ea_nxt = x_circ_on ? circ_fix(x_reg_sum, x_start_r, x_end_r) : x_reg_sum;
      end
      `AGU_M_LITOFS: begin
        x_ea_nxt = x_circ_on ? circ_fix(x_lit_sum, x_start_r, x_end_r) : x_lit_sum;
      end
      default: begin
        x_ea_nxt = x_ptr;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Y generator, word reads for the multiply-accumulate class only

  wire [15:0] y_ptr = default_working_reg_r[Y_PTR_I];
  wire [15:0] y_base = default_working_reg_r[Y_BASE_I];
  wire y_circ_on = y_circ_enable && (y_circ_pointer_select != `AGU_SEL_OFF) &&
    (y_circ_pointer_select == Y_PTR_I);
  wire [15:0] y_step = y_ptr + Y_MOD_I;
  wire [15:0] y_step_fix = y_circ_on ? circ_fix(y_step, y_start_r, y_end_r) : y_step;
  wire [15:0] y_reg_sum = y_ptr + y_base;
  wire [15:0] y_ofs = y_circ_on ? circ_fix(y_reg_sum, y_start_r, y_end_r) : y_reg_sum;
  // Multiply-accumulate fetches use only these three modes; others get no answer
  wire y_mode_ok = (Y_MODE_I == `AGU_M_IND) || (Y_MODE_I == `AGU_M_POST) ||
    (Y_MODE_I == `AGU_M_REGOFS);
  wire y_go = Y_REQ_I && y_mode_ok;
  wire y_wb = y_go && (Y_MODE_I == `AGU_M_POST);
  wire [15:0] y_ea_nxt = (Y_MODE_I == `AGU_M_REGOFS) ? y_ofs : y_ptr;

  wire x_wb = X_REQ_I && x_wb_nxt;

  ////////////////////////////////////////////////////////////////
  // Working registers; pointer updates win over core writes to the same entry

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_default_working_reg
      always @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          default_working_reg_r[gi] <= 16'h0000;
        end else if (x_wb && (X_PTR_I == gi)) begin
          default_working_reg_r[gi] <= x_step_fix;
        end else if (y_wb && (Y_PTR_I == gi)) begin
          default_working_reg_r[gi] <= {y_step_fix[15:1], 1'b0};
        end else if (WR_EN_I && (WR_IDX_I == gi)) begin
          default_working_reg_r[gi] <= WR_DATA_I;
        end
      end
    end
  endgenerate

  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      X_EA_O <= 16'h0000;
      X_EA_VALID_O <= 1'b0;
      X_EA_IS_DATA_O <= 1'b0;
      X_DATA_O <= 16'h0000;
      X_OP1_O <= 16'h0000;
      X_DEST_W0_O <= 1'b0;
      Y_EA_O <= 16'h0000;
      Y_EA_VALID_O <= 1'b0;
    end else begin
      X_EA_VALID_O <= X_REQ_I;
      Y_EA_VALID_O <= y_go;
      if (X_REQ_I) begin
        X_EA_O <= x_ea_nxt;
        X_EA_IS_DATA_O <= x_is_data_nxt;
        X_DATA_O <= x_data_nxt;
        X_OP1_O <= x_base;
        X_DEST_W0_O <= (X_MODE_I == `AGU_M_FILE);
      end
      if (y_go) begin
        Y_EA_O <= {y_ea_nxt[15:1], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Wishbone slave; ack one cycle after the strobe, unmapped reads give zero

  wire wb_go = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire wb_wr = wb_go && WB_WE_I;
  wire [6:0] wb_idx = WB_ADR_I[8:2];
  wire [15:0] wb_mask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [15:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  reg [15:0] rd_nxt;
  always @* begin
    case ({1'b0, wb_idx})
      `AGU_IDX_CTRL: rd_nxt = ctrl_r & `AGU_CTRL_MASK;
      `AGU_IDX_XSTART: rd_nxt = {x_start_r[15:1], 1'b0};
      `AGU_IDX_XEND: rd_nxt = {x_end_r[15:1], 1'b1};
      `AGU_IDX_YSTART: rd_nxt = {y_start_r[15:1], 1'b0};
      `AGU_IDX_YEND: rd_nxt = {y_end_r[15:1], 1'b1};
      `AGU_IDX_BITREV: rd_nxt = bitrev_r;
      `AGU_IDX_INTERRUPT_DISABLE_COUNT: rd_nxt = {2'b00, interrupt_disable_count_r};
      default: rd_nxt = 16'h0000;
    endcase
  end

  // Byte lanes merge into the old value so a one-lane write keeps the other byte
  wire [15:0] disi_wr = merge({2'b00, interrupt_disable_count_r}, WB_DAT_I[15:0], wb_mask);

  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      ctrl_r <= `AGU_CTRL_RST;
      x_start_r <= `AGU_BOUND_RST;
      x_end_r <= `AGU_BOUND_RST;
      y_start_r <= `AGU_BOUND_RST;
      y_end_r <= `AGU_BOUND_RST;
      bitrev_r <= `AGU_BITREV_RST;
      interrupt_disable_count_r <= `AGU_INTERRUPT_DISABLE_COUNT_RST;
      INT_DISABLE_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_go;
      WB_DAT_O <= wb_go ? {16'h0000, rd_nxt} : 32'h00000000;
      INT_DISABLE_O <= (interrupt_disable_count_r != `AGU_INTERRUPT_DISABLE_COUNT_RST);
      // A write to the counter wins over its countdown in the same cycle
      if (wb_wr && ({1'b0, wb_idx} == `AGU_IDX_INTERRUPT_DISABLE_COUNT)) begin
        interrupt_disable_count_r <= disi_wr[`AGU_INTERRUPT_DISABLE_COUNT_W-1:0];
      end else if (interrupt_disable_count_r != `AGU_INTERRUPT_DISABLE_COUNT_RST) begin
        interrupt_disable_count_r <= interrupt_disable_count_r - 14'h0001;
      end
      if (wb_wr) begin
        case ({1'b0, wb_idx})
          `AGU_IDX_CTRL: ctrl_r <= merge(ctrl_r, WB_DAT_I[15:0], wb_mask) & `AGU_CTRL_MASK;
          `AGU_IDX_XSTART: x_start_r <= merge(x_start_r, WB_DAT_I[15:0], wb_mask) & 16'hfffe;
          `AGU_IDX_XEND: x_end_r <= merge(x_end_r, WB_DAT_I[15:0], wb_mask) | 16'h0001;
          `AGU_IDX_YSTART: y_start_r <= merge(y_start_r, WB_DAT_I[15:0], wb_mask) & 16'hfffe;
          `AGU_IDX_YEND: y_end_r <= merge(y_end_r, WB_DAT_I[15:0], wb_mask) | 16'h0001;
          `AGU_IDX_BITREV: bitrev_r <= merge(bitrev_r, WB_DAT_I[15:0], wb_mask);
          default: begin
            // Counter writes are taken above; unmapped writes are dropped
          end
        endcase
      end
    end
  end

endmodule // agu_top

// File: rtl/agu_consts.vh
// Function
// - Two independent generators; Y serves only word reads of multiply-accumulate class.
// - Linear and circular on data or program space; bit-reversed on data only.
// - File-register direct takes address from 13-bit field, lowest 8192 bytes.
// - File-register ops default to working register zero; product op may target pair.
// - Data transfer op in file-register form reaches the whole data space.
// - Three-operand first operand is register direct; second is register, memory, 5-bit literal.
// - Three-operand result to register or memory via direct, indirect, post, pre modes.
// - Register direct uses contents; plain indirect uses pointer unchanged as address.
// - Post-modified: pointer is the address, then pointer changes by a constant.
// - Pre-modified: signed constant added to pointer first, result is the address.
// - Register-offset: address is pointer plus base operand register.
// - Literal-offset: address is pointer plus instruction literal.
// - Unimplemented bit 0 of start bounds and counter bits 15:14 read as zero; end bound bit 0 reads as one.
// - X circular active when X select differs from 15 and control bit 15 set.
// - Y circular active when Y select bits 7:4 differ from 15 and bit 14 set.
// - Bit-reversed needs select not 15, enable set, and pre/post increment mode.
// - Corrected address written back only in pre/post modes; offset modes leave pointer.
`ifndef AGU_CONSTS_VH
`define AGU_CONSTS_VH

// Register indices; byte address is four times the index
`define AGU_IDX_CTRL 8'h46
`define AGU_IDX_XSTART 8'h48
`define AGU_IDX_XEND 8'h4a
`define AGU_IDX_YSTART 8'h4c
`define AGU_IDX_YEND 8'h4e
`define AGU_IDX_BITREV 8'h50
`define AGU_IDX_INTERRUPT_DISABLE_COUNT 8'h52

// Control, bit-reverse and counter register fields
`define AGU_XSEL_LSB 0
`define AGU_YSEL_LSB 4
`define AGU_BSEL_LSB 8
`define AGU_YCIRC_EN_BIT 14
`define AGU_XCIRC_EN_BIT 15
`define AGU_CTRL_MASK 16'hcfff
`define AGU_SEL_OFF 4'hf
`define AGU_BITREV_EN_BIT 15
`define AGU_INTERRUPT_DISABLE_COUNT_W 14

// Reset values
`define AGU_CTRL_RST 16'h0000
`define AGU_BOUND_RST 16'h0000
`define AGU_BITREV_RST 16'h0000
`define AGU_INTERRUPT_DISABLE_COUNT_RST 14'h0000

// Addressing modes
`define AGU_M_FILE 3'h0
`define AGU_M_DIRECT 3'h1
`define AGU_M_IND 3'h2
`define AGU_M_POST 3'h3
`define AGU_M_PRE 3'h4
`define AGU_M_REGOFS 3'h5
`define AGU_M_LITOFS 3'h6
`define AGU_M_LIT5 3'h7

`define AGU_NEAR_MASK 16'h1fff

`endif

// File: tb/agu_chk.sv
`timescale 1ns/100ps
module agu_chk (
  input wire SYS_CLK_I,
  input wire RST_N_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire X_REQ_I,
  input wire [2:0] X_MODE_I,
  input wire [15:0] X_FILE_I,
  input wire X_XFER_I,
  input wire [15:0] X_EA_O,
  input wire X_EA_VALID_O,
  input wire X_DEST_W0_O,
  input wire Y_REQ_I,
  input wire [2:0] Y_MODE_I,
  input wire [15:0] Y_EA_O,
  input wire Y_EA_VALID_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////////////////////////////
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data outside ack");
  a_dat_upper: assert property (WB_DAT_O[31:16] == 16'h0) else $error("upper read bits set");
  a_x_answer: assert property (X_REQ_I |=> X_EA_VALID_O) else $error("x valid missing");
  a_x_quiet: assert property (!X_REQ_I |=> !X_EA_VALID_O) else $error("x valid without request");
  a_near_file: assert property (X_REQ_I && X_MODE_I == 3'h0 && !X_XFER_I
    |=> X_EA_O == ($past(X_FILE_I) & 16'h1fff)) else $error("near file address");
  a_full_file: assert property (X_REQ_I && X_MODE_I == 3'h0 && X_XFER_I
    |=> X_EA_O == $past(X_FILE_I)) else $error("transfer file address");
  a_dest_zero: assert property (X_REQ_I && X_MODE_I == 3'h0 |=> X_DEST_W0_O) else $error("default dest");
  a_y_refuse: assert property (Y_REQ_I && !(Y_MODE_I inside {3'h2, 3'h3, 3'h5})
    |=> !Y_EA_VALID_O) else $error("y mode accepted");
  a_y_word: assert property (Y_EA_VALID_O |-> !Y_EA_O[0]) else $error("y address odd");
endmodule // agu_chk
bind agu_top agu_chk i_chk (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .X_REQ_I(X_REQ_I), .X_MODE_I(X_MODE_I), .X_FILE_I(X_FILE_I),
  .X_XFER_I(X_XFER_I), .X_EA_O(X_EA_O), .X_EA_VALID_O(X_EA_VALID_O), .X_DEST_W0_O(X_DEST_W0_O),
  .Y_REQ_I(Y_REQ_I), .Y_MODE_I(Y_MODE_I), .Y_EA_O(Y_EA_O), .Y_EA_VALID_O(Y_EA_VALID_O));

// File: tb/agu_core_model.sv
`timescale 1ns/100ps
module agu_core_model (
  input wire clk_i,
  input wire rst_n_i,
  input wire load_i,
  input wire [3:0] idx_i,
  input wire [15:0] val_i,
  output reg wr_en_o,
  output reg [3:0] wr_idx_o,
  output reg [15:0] wr_data_o
);
  // Core write stage: one register write a cycle, a cycle after the decoder asks
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_en_o <= 1'b0;
      wr_idx_o <= 4'h0;
      wr_data_o <= 16'h0;
    end else begin
      wr_en_o <= load_i;
      wr_idx_o <= idx_i;
      // Idle data toggles so a stray write is not hidden
      wr_data_o <= load_i ? val_i : ~wr_data_o;
    end
  end
endmodule // agu_core_model

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic [2:0] m; logic [3:0] p; logic [3:0] b; logic [15:0] k; logic xf; logic dt;
    logic [15:0] e;} agu_row_t;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, xq = 0, yq = 0, ld = 0, wen, ack, ev, yv, idis;
  logic [8:0] adr = 9'h0;
  logic [31:0] wd = 32'h0, rd, q;
  logic [3:0] li = 4'h0, widx;
  logic [15:0] lv = 16'h0, wdt, ea, xd, yea, op1;
  logic isd;
  logic [2:0] ym = 3'h0;
  agu_row_t r = '0;
  int n_mismatch = 0, checks = 0;
  // Rows run in order; pointer writebacks carry into later rows
  agu_row_t rows [11] = '{
    '{3'h2, 4'h2, 4'h0, 16'h0000, 1'b0, 1'b0, 16'h1000}, '{3'h3, 4'h2, 4'h0, 16'h0002, 1'b0, 1'b0, 16'h1000},
    '{3'h2, 4'h2, 4'h0, 16'h0000, 1'b0, 1'b0, 16'h1002}, '{3'h4, 4'h2, 4'h0, 16'hfffc, 1'b0, 1'b0, 16'h0ffe},
    '{3'h2, 4'h2, 4'h0, 16'h0000, 1'b0, 1'b0, 16'h0ffe}, '{3'h5, 4'h2, 4'h3, 16'h0000, 1'b0, 1'b0, 16'h100e},
    '{3'h6, 4'h4, 4'h0, 16'h0020, 1'b0, 1'b0, 16'h0820}, '{3'h0, 4'h0, 4'h0, 16'he345, 1'b0, 1'b0, 16'h0345},
    '{3'h0, 4'h0, 4'h0, 16'he345, 1'b1, 1'b0, 16'he345}, '{3'h1, 4'h3, 4'h3, 16'h0000, 1'b0, 1'b1, 16'h0010},
    '{3'h7, 4'h0, 4'h0, 16'h00f7, 1'b0, 1'b1, 16'h0017}};
  initial forever #20 clk = ~clk;
  agu_core_model i_core (.clk_i(clk), .rst_n_i(rst_n), .load_i(ld), .idx_i(li), .val_i(lv), .wr_en_o(wen),
    .wr_idx_o(widx), .wr_data_o(wdt));
  agu_top i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h3), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .X_REQ_I(xq), .X_MODE_I(r.m), .X_PTR_I(r.p),
    .X_BASE_I(r.b), .X_MOD_I(r.k), .X_LIT_I(r.k), .X_FILE_I(r.k), .X_XFER_I(r.xf), .X_EA_O(ea), .X_EA_VALID_O(ev),
    .X_EA_IS_DATA_O(isd), .X_DATA_O(xd), .X_OP1_O(op1), .X_DEST_W0_O(), .Y_REQ_I(yq), .Y_MODE_I(ym),
    .Y_PTR_I(4'h5), .Y_BASE_I(4'h3), .Y_MOD_I(16'h0002), .Y_EA_O(yea), .Y_EA_VALID_O(yv), .WR_EN_I(wen),
    .WR_IDX_I(widx), .WR_DATA_I(wdt), .INT_DISABLE_O(idis));
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wb(input logic w, input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= {16'h0, d};
    // Only the watchdog ends a wait for an acknowledge that never comes
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task wl(input logic [3:0] i, input logic [15:0] v);
    @(posedge clk); ld <= 1; li <= i; lv <= v;
    @(posedge clk); ld <= 0;
    @(posedge clk);
  endtask
  task xr(input agu_row_t v);
    @(posedge clk); r <= v; xq <= 1;
    @(posedge clk); xq <= 0;
    #1 chk("x valid", 1, ev);
    chk("x is data", v.dt, isd);
    chk("x result", v.e, v.dt ? {16'h0, xd} : {16'h0, ea});
  endtask
  task yr(input logic [2:0] m, input logic v);
    @(posedge clk); ym <= m; yq <= 1;
    @(posedge clk); yq <= 0;
    #1 chk("y valid", v, yv);
  endtask
  task test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Run is under two hundred cycles; the limit leaves ample slack
  initial begin repeat (20000) @(posedge clk); n_mismatch++; test_done; end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    wb(0, 9'h118, 0); chk("ctrl reset", 0, q);
    wl(2, 16'h1000); wl(3, 16'h0010); wl(4, 16'h0800);
    foreach (rows[i]) xr(rows[i]);
    xr('{3'h1, 4'h4, 4'h3, 16'h0000, 1'b0, 1'b1, 16'h0800}); chk("x op1", 16'h0010, op1);
    wb(1, 9'h118, 16'hffff); wb(0, 9'h118, 0); chk("ctrl", 32'hcfff, q);
    wb(1, 9'h128, 16'h0000); wb(0, 9'h128, 0); chk("x end", 32'h1, q);
    wb(1, 9'h130, 16'hffff); wb(0, 9'h130, 0); chk("y start", 32'hfffe, q);
    wb(1, 9'h148, 16'hffff); wb(0, 9'h148, 0); chk("count top", 0, q & 32'hffffc000);
    chk("int off", 1, idis);
    wb(1, 9'h148, 16'h0000); wb(0, 9'h1fc, 0); chk("unmapped", 0, q);
    chk("int on", 0, idis);
    // Buffer 1000..1003 on pointer 2; offsets correct the address only
    wb(1, 9'h118, 16'h8ff2); wb(1, 9'h120, 16'h1000); wb(1, 9'h128, 16'h1003);
    wl(2, 16'h1002);
    xr('{3'h3, 4'h2, 4'h0, 16'h0002, 1'b0, 1'b0, 16'h1002});
    xr('{3'h2, 4'h2, 4'h0, 16'h0000, 1'b0, 1'b0, 16'h1000});
    xr('{3'h6, 4'h2, 4'h0, 16'h0006, 1'b0, 1'b0, 16'h1002});
    xr('{3'h2, 4'h2, 4'h0, 16'h0000, 1'b0, 1'b0, 16'h1000});
    wl(5, 16'h2001);
    yr(3'h2, 1); chk("y ea", 16'h2000, yea);
    for (int m = 0; m < 8; m++) yr(m[2:0], m == 2 || m == 3 || m == 5);
    yr(3'h2, 1); chk("y post", 16'h2002, yea);
    // Y buffer 2000..2003 on pointer 5; bit reversal on pointer 2 with pivot 4
    wb(1, 9'h118, 16'h425f); wb(1, 9'h130, 16'h2000); wb(1, 9'h138, 16'h2003); wb(1, 9'h140, 16'h8004);
    yr(3'h3, 1); yr(3'h2, 1); chk("y wrap", 16'h2000, yea);
    xr('{3'h3, 4'h2, 4'h0, 16'h0002, 1'b0, 1'b0, 16'h1000});
    xr('{3'h2, 4'h2, 4'h0, 16'h0000, 1'b0, 1'b0, 16'h1008});
    // Mid-run reset clears pointers, control and outputs alike
    @(posedge clk); rst_n <= 0;
    repeat (2) @(posedge clk);
    chk("ea reset", 0, ea);
    rst_n <= 1;
    wb(0, 9'h118, 0); chk("ctrl cleared", 0, q);
    xr('{3'h2, 4'h2, 4'h0, 16'h0000, 1'b0, 1'b0, 16'h0000});
    test_done;
  end
endmodule // tb
